/* hdl/hpc_pkg.sv */
// Shared constants, register map and state types for the preset compare counter
package hpc_pkg;

    localparam int NUM_GROUPS  = 5;
    localparam int NUM_PRESETS = 6;
    localparam int NUM_INPUTS  = 6;
    localparam int FUNC_W      = 3;

    // Register map: addr[8:6] picks the group, addr[5:0] the offset
    localparam logic [2:0] GROUP_GLOBAL   = 3'h5;
    localparam logic [5:0] OFF_CTRL       = 6'h00;
    localparam logic [5:0] OFF_STATUS     = 6'h04;
    localparam logic [5:0] OFF_COUNT      = 6'h08;
    localparam logic [5:0] OFF_RESET_VAL  = 6'h0c;
    localparam logic [5:0] OFF_ACTIVE     = 6'h10;
    localparam logic [5:0] OFF_CUR_IDX    = 6'h14;
    localparam logic [5:0] OFF_NEXT_IDX   = 6'h18;
    localparam logic [5:0] OFF_OUT_SEL    = 6'h1c;
    localparam logic [5:0] OFF_LABEL      = 6'h20;
    localparam logic [5:0] OFF_PRESET     = 6'h24;
    localparam logic [5:0] OFF_PRESET_END = 6'h3c;
    localparam logic [5:0] OFF_INPUT_FUNC = 6'h00;

    // Control field positions
    localparam int CTRL_GATE    = 0;
    localparam int CTRL_RESET   = 1;
    localparam int CTRL_KEEP    = 2;
    localparam int CTRL_OVF_EN  = 3;
    localparam int CTRL_UNF_EN  = 4;
    localparam int CTRL_IRQ     = 5;
    localparam int CTRL_OUT_RST = 6;
    localparam int CTRL_EDGE4   = 7;
    localparam int CTRL_CLR_EN  = 8;
    localparam int CTRL_NUM     = 9;
    localparam int OUTSEL_OVF   = 12;
    localparam int OUTSEL_UNF   = 14;

    // Reset values and codes
    localparam logic [11:0]       RST_CTRL  = 12'h200;
    localparam logic [2:0]        IDX_FIRST = 3'h1;
    localparam logic [2:0]        IDX_LAST  = 3'h6;
    localparam logic [2:0]        IDX_NONE  = 3'h0;
    localparam logic [FUNC_W-1:0] FUNC_HSC  = 3'h1;
    localparam logic [31:0]       CNT_MAX   = 32'hffff_ffff;

    typedef enum logic [1:0] {
        PH_FIRST  = 2'b00,
        PH_SECOND = 2'b01,
        PH_RUN    = 2'b10
    } hpc_phase_e;

    typedef struct packed {
        logic [8:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } hpc_bus_s;

    typedef struct packed {
        logic [31:0]                  count;
        logic [31:0]                  resetv;
        logic [31:0]                  active;
        logic [31:0]                  pend;
        logic                         pend_v;
        logic [2:0]                   cur;
        logic [2:0]                   next;
        logic [11:0]                  ctrl;
        logic [15:0]                  outsel;
        logic [7:0]                   label;
        logic [NUM_PRESETS-1:0][31:0] slot;
        logic [2:0]                   pending;
        logic [2:0]                   status;
        logic                         dir;
        logic [3:0]                   outs;
    } hpc_grp_s;

    typedef struct packed {
        hpc_grp_s [NUM_GROUPS-1:0]      g;
        logic [NUM_INPUTS*FUNC_W-1:0]   func;
        logic [NUM_INPUTS-1:0]          prev_in;
        hpc_phase_e                     phase;
        logic                           init_relay;
        logic [31:0]                    rdata;
        logic [3:0]                     outs;
        logic                           irq_req;
        logic [7:0]                     irq_label;
        logic [2:0]                     irq_group;
    } hpc_state_s;

endpackage : hpc_pkg

/* hdl/hpc_preset_compare.sv */
// Five-group pulse counter with cyclic multi-preset comparison
// Function
// - On match, current index takes next, next increments
// - After last configured preset, wrap to one
// - Single preset keeps next index at one
// - Current index read-only; next and slots writable
// - Slot rewrite leaves active comparison unchanged
// - Init pulse sets next; second scan activates
// - Count only while gate bit set
// - Comparison-on flag for exactly one scan
// - Match never halts counting
// - Output mode turns on selected output
// - Interrupt mode requests routine with label
// - Overflow condition triggers comparison action
// - Underflow condition triggers comparison action
// - Each condition selects its own output
// - One to six presets per group
// - Active preset rewrite applies at scan end
// - Single-phase groups count rising pulse edges
// - Two-edge mode steps on B edges
// - Four-edge mode steps on A and B edges
// - Two-phase group one only; input two clears
// - Input counts only when set as counter
// - Overflow wraps to zero, flag one scan
// - Underflow wraps to maximum, flag one scan
// - Reset bit loads programmed reset value
// - Keep option skips reload after match
module hpc_preset_compare (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [5:0]        in_pin,
    input  wire logic              scan_end,
    input  wire hpc_pkg::hpc_bus_s bus,
    output logic [31:0]            rdata,
    output logic                   compare_output_first,
    output logic                   compare_output_second,
    output logic                   compare_output_third,
    output logic                   compare_output_last,
    output logic                   irq_request,
    output logic [7:0]             irq_label,
    output logic [2:0]             irq_group,
    output logic                   init_pulse_relay
);

    localparam int NG = hpc_pkg::NUM_GROUPS;

    hpc_pkg::hpc_state_s st;
    hpc_pkg::hpc_state_s next_st;
    logic [NG-1:0]       step;
    logic [NG-1:0]       up;
    logic [NG-1:0]       hit;
    logic [NG-1:0]       ovf;
    logic [NG-1:0]       unf;
    logic [NG-1:0]       clr;
    logic [5:0]          hsc;
    logic [5:0]          rise;
    logic [5:0]          chg;
    logic [31:0]         newc;
    logic [5:0]          rel;
    logic [2:0]          osel;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] slot_of(input logic [2:0] idx);
        slot_of = (idx == hpc_pkg::IDX_NONE) ? 3'h0 : 3'(idx - 3'h1);
    endfunction : slot_of

    // Wrap at the configured count keeps a single-preset group on one
    function automatic logic [2:0] advance(input logic [2:0] idx, input logic [2:0] num);
        advance = (idx >= num) ? hpc_pkg::IDX_FIRST : 3'(idx + 3'h1);
    endfunction : advance

    function automatic logic [2:0] clamp_idx(input logic [2:0] v);
        if (v == hpc_pkg::IDX_NONE)
            clamp_idx = hpc_pkg::IDX_FIRST;
        else if (v > hpc_pkg::IDX_LAST)
            clamp_idx = hpc_pkg::IDX_LAST;
        else
            clamp_idx = v;
    endfunction : clamp_idx

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        next_st.prev_in = in_pin;
        next_st.irq_req = 1'b0;
        next_st.rdata = 32'h0000_0000;
        newc = 32'h0000_0000;
        rel = 6'h00;
        osel = 3'h0;
        rise = in_pin & ~st.prev_in;
        chg = in_pin ^ st.prev_in;
        for (int i = 0; i < hpc_pkg::NUM_INPUTS; i++)
        begin
            hsc[i] = st.func[i*hpc_pkg::FUNC_W +: hpc_pkg::FUNC_W] == hpc_pkg::FUNC_HSC;
        end
        for (int g = 0; g < NG; g++)
        begin
            step[g] = 1'b0;
            up[g] = 1'b1;
            hit[g] = 1'b0;
            ovf[g] = 1'b0;
            unf[g] = 1'b0;
            clr[g] = 1'b0;
        end
        // In four-edge mode simultaneous A and B changes are ambiguous and dropped
        if (hsc[0] && hsc[1])
        begin
            step[0] = st.g[0].ctrl[hpc_pkg::CTRL_EDGE4] ? (chg[0] ^ chg[1]) : chg[1];
            up[0] = in_pin[0] ^ st.prev_in[1];
        end
        clr[0] = st.g[0].ctrl[hpc_pkg::CTRL_CLR_EN] && hsc[2] && rise[2];
        for (int g = 1; g < NG; g++)
        begin
            step[g] = hsc[g+1] && rise[g+1] && !(g == 1 && st.g[0].ctrl[hpc_pkg::CTRL_CLR_EN]);
        end

        for (int g = 0; g < NG; g++)
        begin
            // Bus writes first so that hardware events below take priority
            if (bus.wr && bus.addr[8:6] == 3'(g))
            begin
                rel = 6'(bus.addr[5:0] - hpc_pkg::OFF_PRESET);
                case (bus.addr[5:0])
                    hpc_pkg::OFF_CTRL:
                    begin
                        next_st.g[g].ctrl = bus.wdata[11:0];
                        next_st.g[g].ctrl[hpc_pkg::CTRL_NUM +: 3] = clamp_idx(bus.wdata[11:9]);
                        if (g != 0)
                        begin
                            next_st.g[g].ctrl[hpc_pkg::CTRL_CLR_EN] = 1'b0;
                            next_st.g[g].ctrl[hpc_pkg::CTRL_EDGE4] = 1'b0;
                            next_st.g[g].ctrl[hpc_pkg::CTRL_UNF_EN] = 1'b0;
                        end
                    end
                    hpc_pkg::OFF_RESET_VAL: next_st.g[g].resetv = bus.wdata;
                    hpc_pkg::OFF_ACTIVE:
                    begin
                        next_st.g[g].pend = bus.wdata;
                        next_st.g[g].pend_v = 1'b1;
                    end
                    hpc_pkg::OFF_NEXT_IDX: next_st.g[g].next = clamp_idx(bus.wdata[2:0]);
                    hpc_pkg::OFF_OUT_SEL: next_st.g[g].outsel = bus.wdata[15:0];
                    hpc_pkg::OFF_LABEL: next_st.g[g].label = bus.wdata[7:0];
                    default:
                    begin
                        // Current index and status are read-only; writes drop
                        if (bus.addr[5:0] >= hpc_pkg::OFF_PRESET && bus.addr[5:0] <= hpc_pkg::OFF_PRESET_END)
                            next_st.g[g].slot[rel[4:2]] = bus.wdata;
                    end
                endcase
            end

            // Pending rewrite of the live target lands only at scan end
            if (scan_end && st.g[g].pend_v)
            begin
                next_st.g[g].active = next_st.g[g].pend;
                next_st.g[g].pend_v = 1'b0;
            end

            if (st.g[g].ctrl[hpc_pkg::CTRL_RESET] || clr[g])
                next_st.g[g].count = st.g[g].resetv;
            else if (st.g[g].ctrl[hpc_pkg::CTRL_GATE] && step[g])
            begin
                newc = up[g] ? 32'(st.g[g].count + 32'h1) : 32'(st.g[g].count - 32'h1);
                ovf[g] = up[g] && st.g[g].count == hpc_pkg::CNT_MAX;
                unf[g] = !up[g] && st.g[g].count == 32'h0000_0000 && g == 0;
                hit[g] = st.phase == hpc_pkg::PH_RUN && st.g[g].cur != hpc_pkg::IDX_NONE
                         && newc == st.g[g].active;
                next_st.g[g].count = (hit[g] && !st.g[g].ctrl[hpc_pkg::CTRL_KEEP]) ? st.g[g].resetv : newc;
                if (g == 0)
                    next_st.g[g].dir = up[g];
            end

            if (hit[g])
            begin
                next_st.g[g].cur = next_st.g[g].next;
                next_st.g[g].active = st.g[g].slot[slot_of(next_st.g[g].next)];
                next_st.g[g].next = advance(next_st.g[g].next, st.g[g].ctrl[hpc_pkg::CTRL_NUM +: 3]);
            end

            if (st.g[g].ctrl[hpc_pkg::CTRL_OUT_RST])
                next_st.g[g].outs = 4'h0;
            if (!st.g[g].ctrl[hpc_pkg::CTRL_IRQ])
            begin
                // Two select bits per preset, indexed by the preset that matched
                osel = slot_of(st.g[g].cur);
                if (hit[g])
                    next_st.g[g].outs[st.g[g].outsel[{osel, 1'b0} +: 2]] = 1'b1;
                if (ovf[g] && st.g[g].ctrl[hpc_pkg::CTRL_OVF_EN])
                    next_st.g[g].outs[st.g[g].outsel[hpc_pkg::OUTSEL_OVF +: 2]] = 1'b1;
                if (unf[g] && st.g[g].ctrl[hpc_pkg::CTRL_UNF_EN])
                    next_st.g[g].outs[st.g[g].outsel[hpc_pkg::OUTSEL_UNF +: 2]] = 1'b1;
            end
            else if (!next_st.irq_req && (hit[g] || (ovf[g] && st.g[g].ctrl[hpc_pkg::CTRL_OVF_EN])
                     || (unf[g] && st.g[g].ctrl[hpc_pkg::CTRL_UNF_EN])))
            begin
                // Lowest group wins a same-cycle collision
                next_st.irq_req = 1'b1;
                next_st.irq_label = st.g[g].label;
                next_st.irq_group = 3'(g);
            end

            // A new event in the strobe cycle is shown, not lost
            if (scan_end)
            begin
                next_st.g[g].status = st.g[g].pending | {unf[g], ovf[g], hit[g]};
                next_st.g[g].pending = 3'h0;
            end
            else
                next_st.g[g].pending = st.g[g].pending | {unf[g], ovf[g], hit[g]};

            if (st.phase == hpc_pkg::PH_FIRST)
                next_st.g[g].next = hpc_pkg::IDX_FIRST;
            else if (st.phase == hpc_pkg::PH_SECOND && scan_end)
            begin
                next_st.g[g].cur = st.g[g].next;
                next_st.g[g].active = st.g[g].slot[slot_of(st.g[g].next)];
                next_st.g[g].next = advance(st.g[g].next, st.g[g].ctrl[hpc_pkg::CTRL_NUM +: 3]);
            end
        end

        if (bus.wr && bus.addr[8:6] == hpc_pkg::GROUP_GLOBAL && bus.addr[5:0] == hpc_pkg::OFF_INPUT_FUNC)
            next_st.func = bus.wdata[hpc_pkg::NUM_INPUTS*hpc_pkg::FUNC_W-1:0];

        case (st.phase)
            hpc_pkg::PH_FIRST:
            begin
                next_st.init_relay = !scan_end;
                next_st.phase = scan_end ? hpc_pkg::PH_SECOND : hpc_pkg::PH_FIRST;
            end
            hpc_pkg::PH_SECOND:
            begin
                next_st.init_relay = 1'b0;
                next_st.phase = scan_end ? hpc_pkg::PH_RUN : hpc_pkg::PH_SECOND;
            end
            hpc_pkg::PH_RUN:
            begin
                next_st.init_relay = 1'b0;
            end
            default:
            begin
                next_st.init_relay = 1'b0;
                next_st.phase = hpc_pkg::PH_RUN;
            end
        endcase

        next_st.outs = 4'h0;
        for (int g = 0; g < NG; g++)
        begin
            next_st.outs = next_st.outs | next_st.g[g].outs;
        end

        if (bus.rd)
        begin
            if (bus.addr[8:6] < hpc_pkg::GROUP_GLOBAL)
            begin
                rel = 6'(bus.addr[5:0] - hpc_pkg::OFF_PRESET);
                case (bus.addr[5:0])
                    hpc_pkg::OFF_CTRL: next_st.rdata = {20'h0_0000, st.g[bus.addr[8:6]].ctrl};
                    hpc_pkg::OFF_STATUS: next_st.rdata = {24'h00_0000, st.g[bus.addr[8:6]].outs,
                                                    st.g[bus.addr[8:6]].dir, st.g[bus.addr[8:6]].status};
                    hpc_pkg::OFF_COUNT: next_st.rdata = st.g[bus.addr[8:6]].count;
                    hpc_pkg::OFF_RESET_VAL: next_st.rdata = st.g[bus.addr[8:6]].resetv;
                    hpc_pkg::OFF_ACTIVE: next_st.rdata = st.g[bus.addr[8:6]].active;
                    hpc_pkg::OFF_CUR_IDX: next_st.rdata = {29'h0000_0000, st.g[bus.addr[8:6]].cur};
                    hpc_pkg::OFF_NEXT_IDX: next_st.rdata = {29'h0000_0000, st.g[bus.addr[8:6]].next};
                    hpc_pkg::OFF_OUT_SEL: next_st.rdata = {16'h0000, st.g[bus.addr[8:6]].outsel};
                    hpc_pkg::OFF_LABEL: next_st.rdata = {24'h00_0000, st.g[bus.addr[8:6]].label};
                    default:
                    begin
                        if (bus.addr[5:0] >= hpc_pkg::OFF_PRESET && bus.addr[5:0] <= hpc_pkg::OFF_PRESET_END)
                            next_st.rdata = st.g[bus.addr[8:6]].slot[rel[4:2]];
                    end
                endcase
            end
            else if (bus.addr[8:6] == hpc_pkg::GROUP_GLOBAL && bus.addr[5:0] == hpc_pkg::OFF_INPUT_FUNC)
                next_st.rdata = {14'h0000, st.func};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '0;
            st.init_relay <= 1'b1;
            for (int g = 0; g < NG; g++)
            begin
                st.g[g].ctrl <= hpc_pkg::RST_CTRL;
                st.g[g].next <= hpc_pkg::IDX_FIRST;
            end
        end
        else
            st <= next_st;
    end

    assign rdata = st.rdata;
    assign compare_output_first = st.outs[0];
    assign compare_output_second = st.outs[1];
    assign compare_output_third = st.outs[2];
    assign compare_output_last = st.outs[3];
    assign irq_request = st.irq_req;
    assign irq_label = st.irq_label;
    assign irq_group = st.irq_group;
    assign init_pulse_relay = st.init_relay;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Most checks watch group three, the one driven through full preset cycles
    sequence s_hit_cycle;
        hit[2] && !bus.wr;
    endsequence

    sequence s_out_hit0;
        hit[0] && !st.g[0].ctrl[hpc_pkg::CTRL_IRQ] && !st.g[0].ctrl[hpc_pkg::CTRL_OUT_RST];
    endsequence

    idx_advance_a: assert property (s_hit_cycle |=> st.g[2].cur == $past(st.g[2].next))
        else $error("current index did not take next index");

    idx_wrap_a: assert property (s_hit_cycle ##0 (st.g[2].next == st.g[2].ctrl[hpc_pkg::CTRL_NUM +: 3])
        |=> st.g[2].next == hpc_pkg::IDX_FIRST)
        else $error("next index did not wrap to one");

    single_preset_a: assert property (hit[0] && !bus.wr && st.g[0].ctrl[hpc_pkg::CTRL_NUM +: 3] == 3'h1
        |=> st.g[0].next == hpc_pkg::IDX_FIRST && st.g[0].cur == hpc_pkg::IDX_FIRST)
        else $error("single preset index moved");

    gate_hold_a: assert property (!st.g[3].ctrl[hpc_pkg::CTRL_GATE] && !st.g[3].ctrl[hpc_pkg::CTRL_RESET]
        |=> st.g[3].count == $past(st.g[3].count))
        else $error("count moved with gate off");

    add_step_a: assert property (step[2] && st.g[2].ctrl[hpc_pkg::CTRL_GATE] && !st.g[2].ctrl[hpc_pkg::CTRL_RESET]
        && st.g[2].ctrl[hpc_pkg::CTRL_KEEP] |=> st.g[2].count == 32'($past(st.g[2].count) + 32'h1))
        else $error("pulse edge did not add one");

    reset_load_a: assert property (st.g[2].ctrl[hpc_pkg::CTRL_RESET]
        |=> st.g[2].count == $past(st.g[2].resetv))
        else $error("reset bit did not load reset value");

    cmp_flag_a: assert property (scan_end && (hit[2] || st.g[2].pending[0])
        |=> st.g[2].status[0])
        else $error("comparison flag missed its scan");

    cmp_flag_drop_a: assert property (scan_end && !hit[2] && !st.g[2].pending[0]
        |=> !st.g[2].status[0])
        else $error("comparison flag held over a second scan");

    status_hold_a: assert property (!scan_end |=> st.g[2].status == $past(st.g[2].status))
        else $error("status flags changed between scan ends");

    out_set_a: assert property (s_out_hit0 |=> ##1 st.outs != 4'h0)
        else $error("comparison output not turned on");

    ovf_wrap_a: assert property (ovf[2] && st.g[2].ctrl[hpc_pkg::CTRL_KEEP]
        |=> st.g[2].count == 32'h0000_0000)
        else $error("overflow did not wrap to zero");

    keep_count_a: assert property (hit[2] && st.g[2].ctrl[hpc_pkg::CTRL_KEEP]
        |=> st.g[2].count == $past(st.g[2].active))
        else $error("count stopped at a match");

    init_activate_a: assert property (st.phase == hpc_pkg::PH_SECOND && scan_end
        |=> st.g[0].cur == $past(st.g[0].next) && !init_pulse_relay)
        else $error("second scan end did not activate preset");

endmodule : hpc_preset_compare

/* testbench/hpc_pulse_src.sv */
// Pulse and quadrature source that drives the counter inputs
module hpc_pulse_src (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       step,
    input  wire logic       quad,
    input  wire logic       up,
    input  wire logic [2:0] sel,
    output logic [5:0]      in_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // One edge per step, so no two inputs ever change in the same clock
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            in_pin <= 6'h00;
        else if (step && quad)
        begin
            if ((in_pin[0] == in_pin[1]) == up)
                in_pin[0] <= !in_pin[0];
            else
                in_pin[1] <= !in_pin[1];
        end
        else if (step)
            in_pin[sel] <= !in_pin[sel];
    end
endmodule : hpc_pulse_src

/* testbench/hpc_preset_compare_test.sv */
// Self-checking bench for the preset compare counter
module hpc_preset_compare_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, scan_end, step, quad, up, irq_seen;
    logic [2:0] sel;
    logic [5:0] in_pin;
    logic [31:0] rdata, got;
    logic [3:0] outs;
    logic [7:0] irq_label, lab;
    logic init_relay, irq_request;
    logic [2:0] irq_grp, grp;
    hpc_pkg::hpc_bus_s bus;
    int fails, tests_run, cyc;

    hpc_pulse_src SRC (.clk(clk), .reset_n(reset_n), .step(step), .quad(quad), .up(up), .sel(sel),
        .in_pin(in_pin));
    hpc_preset_compare DUT (.clk(clk), .reset_n(reset_n), .in_pin(in_pin), .scan_end(scan_end),
        .bus(bus), .rdata(rdata), .compare_output_first(outs[0]), .compare_output_second(outs[1]),
        .compare_output_third(outs[2]), .compare_output_last(outs[3]), .irq_request(irq_request),
        .irq_label(irq_label), .irq_group(irq_grp), .init_pulse_relay(init_relay));

    ////////////////////////////////////////
    task automatic stop_test;
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            $display("Error %0t got %h exp %h", $time, g, e);
            fails++;
        end
    endtask : chk

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus <= '0;
    endtask : wr

    task automatic rd(input logic [8:0] a);
        @(posedge clk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk) bus <= '0;
        #1 got = rdata;
    endtask : rd

    task automatic scan;
        @(posedge clk) scan_end <= 1'b1;
        @(posedge clk) scan_end <= 1'b0;
    endtask : scan

    task automatic edge1(input logic [2:0] s, input logic q, input logic u);
        @(posedge clk)
        begin
            step <= 1'b1; sel <= s; quad <= q; up <= u;
        end
        @(posedge clk) step <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : edge1

    ////////////////////////////////////////
    // Group three: presets 2, 4, 6 driving outputs 0, 1, 3
    task automatic t_init;
        chk(32'(init_relay), 32'h1);
        wr(9'h140, 32'h209);
        wr(9'h0a4, 32'h2);
        wr(9'h0a8, 32'h4);
        wr(9'h0ac, 32'h6);
        wr(9'h09c, 32'h34);
        wr(9'h080, 32'h604);
        scan();
        #1 chk(32'(init_relay), 32'h0);
        scan();
        rd(9'h094); chk(got, 32'h1);
        rd(9'h098); chk(got, 32'h2);
        rd(9'h018); chk(got, 32'h1);
        wr(9'h094, 32'h5);
        rd(9'h094); chk(got, 32'h1);
    endtask : t_init

    task automatic t_cycle;
        edge1(3'h3, 1'b0, 1'b1); edge1(3'h3, 1'b0, 1'b1);
        rd(9'h088); chk(got, 32'h0);
        wr(9'h080, 32'h605);
        for (int k = 1; k <= 6; k++)
        begin
            edge1(3'h3, 1'b0, 1'b1); edge1(3'h3, 1'b0, 1'b1);
        end
        rd(9'h088); chk(got, 32'h6);
        chk(32'(outs), 32'hb);
        rd(9'h094); chk(got, 32'h1);
        rd(9'h098); chk(got, 32'h2);
    endtask : t_cycle

    task automatic t_ovf;
        wr(9'h08c, 32'hffff_ffff);
        wr(9'h0a0, 32'h5a);
        wr(9'h080, 32'h62f);
        wr(9'h080, 32'h62d);
        rd(9'h088); chk(got, 32'hffff_ffff);
        irq_seen = 1'b0;
        edge1(3'h3, 1'b0, 1'b1); edge1(3'h3, 1'b0, 1'b1);
        rd(9'h088); chk(got, 32'h0);
        chk(32'(irq_seen), 32'h1);
        chk(32'(lab), 32'h5a);
        chk(32'(grp), 32'h2);
        scan();
        rd(9'h084); chk(got & 32'h2, 32'h2);
        chk(got & 32'h1, 32'h1);
        scan();
        rd(9'h084); chk(got & 32'h2, 32'h0);
    endtask : t_ovf

    task automatic t_quad;
        wr(9'h000, 32'h281);
        wr(9'h010, 32'h2);
        rd(9'h010); chk(got, 32'h0);
        scan();
        rd(9'h010); chk(got, 32'h2);
        // Second up step matches 2 and reloads zero, no keep
        repeat (4) edge1(3'h0, 1'b1, 1'b1);
        edge1(3'h0, 1'b1, 1'b0);
        rd(9'h008); chk(got, 32'h1);
        rd(9'h014); chk(got, 32'h1);
        wr(9'h000, 32'h201);
        repeat (2) edge1(3'h0, 1'b1, 1'b1);
        rd(9'h008); chk(got, 32'h2);
    endtask : t_quad

    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end

    // Interrupt requests stand one cycle, so catch them here
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (irq_request === 1'b1)
        begin
            irq_seen <= 1'b1;
            lab <= irq_label;
            grp <= irq_grp;
        end
        if (cyc == 20000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        reset_n = 1'b0; scan_end = 1'b0; step = 1'b0; quad = 1'b0; up = 1'b0;
        sel = 3'h0; bus = '0; irq_seen = 1'b0; lab = 8'h00; cyc = 0; grp = 3'h0;
        fails = 0; tests_run = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_init();
        t_cycle();
        t_ovf();
        t_quad();
        stop_test();
    end
endmodule : hpc_preset_compare_test
